// ---- rtl/dgp_pin_sync.sv ----
// Two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none
module dgp_pin_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         pclk,     // System clock
    input  wire logic         presetn,  // Async reset, active low
    input  wire logic [W-1:0] pin_in,   // Raw pin levels
    output var  logic [W-1:0] pin_sync  // Synchronised levels
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q   <= '0;
            pin_sync <= '0;
        end
        else
        begin
            meta_q   <= pin_in;
            pin_sync <= meta_q;
        end
    end
endmodule // dgp_pin_sync

`default_nettype wire

// ---- rtl/dgp_pkg.sv ----
// Package for the dual general-purpose port block
package dgp_pkg;
    localparam int unsigned DGP_WIDE_W   = 8;
    localparam int unsigned DGP_NARROW_W = 3;
    // Byte addresses on APB
    localparam logic [7:0] DGP_OFF_WIDE_PINS   = 8'h00;
    localparam logic [7:0] DGP_OFF_WIDE_LATCH  = 8'h04;
    localparam logic [7:0] DGP_OFF_WIDE_DIR    = 8'h08;
    localparam logic [7:0] DGP_OFF_NARROW_PINS = 8'h0C;
    localparam logic [7:0] DGP_OFF_NARROW_LAT  = 8'h10;
    localparam logic [7:0] DGP_OFF_NARROW_DIR  = 8'h14;
    localparam logic [7:0] DGP_OFF_ANALOG_CFG  = 8'h18;
    // Field positions of the narrow direction/host control register
    localparam int unsigned DGP_BIT_HOST_MODE  = 4;
    localparam int unsigned DGP_BIT_IN_OVF     = 5;
    localparam int unsigned DGP_BIT_OUT_FULL   = 6;
    localparam int unsigned DGP_BIT_IN_FULL    = 7;
    // Reset values
    localparam logic [7:0] DGP_RST_WIDE_DIR    = 8'hFF;
    localparam logic [7:0] DGP_RST_NARROW_DIR  = 8'h07;
    localparam logic [2:0] DGP_RST_ANALOG_CFG  = 3'h0;
    localparam logic [7:0] DGP_RST_LATCH       = 8'h00;
    // Analog config code that makes all narrow pins digital (all bits set)
    localparam logic [2:0] DGP_ANALOG_ALL_DIG  = 3'h7;
endpackage : dgp_pkg

// ---- rtl/dgp_top.sv ----
// Dual general-purpose port with APB register access
//
// Overview of operation
// - Wide direction bit 1 makes that pin input, driver released.
// - Wide direction bit 0 drives the pin from the output latch.
// - Wide output latch has its own address and reads back latch.
// - Eight wide pins, each with its own direction bit.
// - Power-on reset sets all eight wide direction bits to one.
// - Host mode bit 4 turns the wide port into a host port.
// - Narrow direction bit 1 makes that pin input, driver released.
// - Narrow direction bit 0 drives the pin from its latch.
// - Narrow output latch has its own address and reads back latch.
// - Narrow port has exactly three individually settable pins.
// - Narrow direction register resets to 0000 -111.
// - Narrow pins selected analog read as zero.
// - Direction bits still control drivers while pins are analog.
// - Power-on reset selects all narrow pins as analog.
// - Narrow direction bits 2..0 set pin directions; bit 3 reads zero.
`timescale 1ns/1ps
`default_nettype none
module dgp_top
    import dgp_pkg::*;
#(
    parameter int unsigned WIDE_W   = DGP_WIDE_W,
    parameter int unsigned NARROW_W = DGP_NARROW_W
) (
    input  wire logic                pclk,         // 250 MHz clock
    input  wire logic                presetn,      // Power-on reset, async low
    input  wire logic                soft_rst_n,   // Other reset, sync low
    input  wire logic                psel,         // APB select
    input  wire logic                penable,      // APB enable
    input  wire logic                pwrite,       // APB direction
    input  wire logic [7:0]          paddr,        // APB byte address
    input  wire logic [31:0]         pwdata,       // APB write data
    input  wire logic [3:0]          pstrb,        // APB byte strobes
    output var  logic                pready,       // APB ready
    output var  logic [31:0]         prdata,       // APB read data
    output var  logic                pslverr,      // APB error
    input  wire logic [WIDE_W-1:0]   wide_pin_i,   // Wide pin levels
    output var  logic [WIDE_W-1:0]   wide_pin_o,   // Wide pin drive value
    output var  logic [WIDE_W-1:0]   wide_pin_oe,  // Wide pin drive enable
    input  wire logic [NARROW_W-1:0] narrow_pin_i, // Narrow pin levels
    output var  logic [NARROW_W-1:0] narrow_pin_o, // Narrow pin drive value
    output var  logic [NARROW_W-1:0] narrow_pin_oe,// Narrow pin drive enable
    output var  logic                host_port_mode_select // Host port mode
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [WIDE_W-1:0]   wide_lat;
        logic [WIDE_W-1:0]   wide_dir;
        logic [NARROW_W-1:0] nar_lat;
        logic [NARROW_W-1:0] nar_dir;
        logic                host_mode;
        logic [2:0]          analog_cfg;
        logic                ready;
        logic [31:0]         rdata;
        logic                err;
        logic [WIDE_W-1:0]   wide_o;
        logic [WIDE_W-1:0]   wide_oe;
        logic [NARROW_W-1:0] nar_o;
        logic [NARROW_W-1:0] nar_oe;
    } dgp_state_s;

    dgp_state_s st_q;
    dgp_state_s st_d;

    logic [WIDE_W-1:0]   wide_sync;
    logic [NARROW_W-1:0] nar_sync;
    logic [NARROW_W-1:0] nar_read;
    logic [7:0]          nar_ctrl_rd;
    logic                acc;
    logic                wr;
    logic                known;

    ////////////////////////////////////////////////////////////////////////
    // Pins cross into pclk before any read path
    dgp_pin_sync #(.W(WIDE_W)) u_wide_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   (wide_pin_i),
        .pin_sync (wide_sync)
    );

    dgp_pin_sync #(.W(NARROW_W)) u_nar_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   (narrow_pin_i),
        .pin_sync (nar_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    assign acc   = psel && penable && !st_q.ready;
    assign wr    = acc && pwrite && pstrb[0];
    assign known = (paddr == DGP_OFF_WIDE_PINS)   || (paddr == DGP_OFF_WIDE_LATCH)
                || (paddr == DGP_OFF_WIDE_DIR)    || (paddr == DGP_OFF_NARROW_PINS)
                || (paddr == DGP_OFF_NARROW_LAT)  || (paddr == DGP_OFF_NARROW_DIR)
                || (paddr == DGP_OFF_ANALOG_CFG);

    // analog-selected pins read zero
    // Only the all-digital code frees the pins; other codes keep them analog
    assign nar_read = (st_q.analog_cfg == DGP_ANALOG_ALL_DIG) ? nar_sync : '0;

    // bit 3 and status bits read zero
    // Host handshake flags are not built here, so they read as zero
    always_comb
    begin
        nar_ctrl_rd = 8'h00;
        nar_ctrl_rd[NARROW_W-1:0] = st_q.nar_dir;
        nar_ctrl_rd[DGP_BIT_HOST_MODE] = st_q.host_mode;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d       = st_q;
        st_d.ready = 1'b0;
        st_d.err   = 1'b0;
        // other reset keeps latches and wide direction
        if (!soft_rst_n)
        begin
            // narrow control back to 0000 -111
            st_d.nar_dir   = DGP_RST_NARROW_DIR[NARROW_W-1:0];
            st_d.host_mode = 1'b0;
        end
        else if (acc)
        begin
            st_d.ready = 1'b1;
            st_d.err   = !known;
            st_d.rdata = 32'h0000_0000;
            unique case (paddr)
                DGP_OFF_WIDE_PINS:
                begin
                    // pins read, writes hit the latch
                    st_d.rdata[WIDE_W-1:0] = wide_sync;
                    if (wr)
                        st_d.wide_lat = pwdata[WIDE_W-1:0];
                end
                DGP_OFF_WIDE_LATCH:
                begin
                    st_d.rdata[WIDE_W-1:0] = st_q.wide_lat;
                    if (wr)
                        st_d.wide_lat = pwdata[WIDE_W-1:0];
                end
                DGP_OFF_WIDE_DIR:
                begin
                    // one direction bit per wide pin
                    st_d.rdata[WIDE_W-1:0] = st_q.wide_dir;
                    if (wr)
                        st_d.wide_dir = pwdata[WIDE_W-1:0];
                end
                DGP_OFF_NARROW_PINS:
                begin
                    // narrow pins read, writes hit the latch
                    st_d.rdata[NARROW_W-1:0] = nar_read;
                    if (wr)
                        st_d.nar_lat = pwdata[NARROW_W-1:0];
                end
                DGP_OFF_NARROW_LAT:
                begin
                    st_d.rdata[NARROW_W-1:0] = st_q.nar_lat;
                    if (wr)
                        st_d.nar_lat = pwdata[NARROW_W-1:0];
                end
                DGP_OFF_NARROW_DIR:
                begin
                    // three direction bits plus host mode
                    st_d.rdata[7:0] = nar_ctrl_rd;
                    if (wr)
                    begin
                        st_d.nar_dir   = pwdata[NARROW_W-1:0];
                        st_d.host_mode = pwdata[DGP_BIT_HOST_MODE];
                    end
                end
                DGP_OFF_ANALOG_CFG:
                begin
                    st_d.rdata[2:0] = st_q.analog_cfg;
                    if (wr)
                        st_d.analog_cfg = pwdata[2:0];
                end
                default:
                begin
                    st_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        // direction 1 releases the wide driver
        // direction 0 drives the wide latch value
        // host mode hands the wide pins to the host port (held released)
        st_d.wide_o  = st_d.wide_lat;
        st_d.wide_oe = st_d.host_mode ? '0 : ~st_d.wide_dir;
        // narrow direction 1 releases the driver
        // narrow direction 0 drives from its latch
        // analog selection does not override direction
        st_d.nar_o  = st_d.nar_lat;
        st_d.nar_oe = ~st_d.nar_dir;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q            <= '0;
            st_q.wide_lat   <= DGP_RST_LATCH[WIDE_W-1:0];
            st_q.wide_dir   <= DGP_RST_WIDE_DIR[WIDE_W-1:0];
            st_q.nar_lat    <= DGP_RST_LATCH[NARROW_W-1:0];
            st_q.nar_dir    <= DGP_RST_NARROW_DIR[NARROW_W-1:0];
            st_q.analog_cfg <= DGP_RST_ANALOG_CFG;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign pready                = st_q.ready;
    assign prdata                = st_q.rdata;
    assign pslverr               = st_q.err;
    assign wide_pin_o            = st_q.wide_o;
    assign wide_pin_oe           = st_q.wide_oe;
    assign narrow_pin_o          = st_q.nar_o;
    assign narrow_pin_oe         = st_q.nar_oe;
    assign host_port_mode_select = st_q.host_mode;

    ////////////////////////////////////////////////////////////////////////
    sequence s_dir_write(logic [7:0] a);
        psel && penable && pwrite && pstrb[0] && !pready && soft_rst_n && (paddr == a);
    endsequence

    // Read taken on the first access cycle, answered one cycle later
    sequence s_reg_read(logic [7:0] a);
        psel && penable && !pwrite && !pready && soft_rst_n && (paddr == a);
    endsequence

    a_wide_dir_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> (st_q.wide_dir == DGP_RST_WIDE_DIR[WIDE_W-1:0]))
        else $error("wide direction not all ones after reset");

    a_wide_input_float: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q.wide_dir == '1) |-> (wide_pin_oe == '0))
        else $error("wide input pin driven");

    a_wide_drive_latch: assert property (@(posedge pclk) disable iff (!presetn)
        (!host_port_mode_select) |-> ((wide_pin_oe == ~st_q.wide_dir)
        && (wide_pin_o == st_q.wide_lat)))
        else $error("wide output not from latch");

    a_wide_latch_rmw: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg_read(DGP_OFF_WIDE_LATCH) |=> (prdata[WIDE_W-1:0] == wide_pin_o)
        && (prdata[31:WIDE_W] == '0))
        else $error("wide latch readback wrong");

    a_host_mode_float: assert property (@(posedge pclk) disable iff (!presetn)
        host_port_mode_select |-> (wide_pin_oe == '0))
        else $error("wide pins driven in host mode");

    a_nar_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (narrow_pin_oe == ~st_q.nar_dir) && (narrow_pin_o == st_q.nar_lat))
        else $error("narrow drive mismatch");

    a_nar_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_dir_write(DGP_OFF_NARROW_DIR) |=> (narrow_pin_oe == ~$past(pwdata[2:0]))
        && (host_port_mode_select == $past(pwdata[4])))
        else $error("narrow direction write lost");

    a_nar_analog_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && !pready && paddr == DGP_OFF_NARROW_PINS
        && st_q.analog_cfg != DGP_ANALOG_ALL_DIG) |=> (prdata == 32'h0000_0000))
        else $error("analog pin read nonzero");

    a_soft_rst_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        !soft_rst_n |=> (narrow_pin_oe == '0) && !host_port_mode_select)
        else $error("narrow control not reset");

    a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |-> ##1 pready)
        else $error("no answer one cycle after access");

    ////////////////////////////////////////////////////////////////////////
    // Answer pulse stands for one cycle only
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held past one cycle");

    // Refused address answers with an error and no data
    a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && soft_rst_n && !known) |=> pslverr
        && (prdata == 32'h0000_0000))
        else $error("unmapped address not refused");

    // latch write reaches the drive value
    a_wide_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_dir_write(DGP_OFF_WIDE_LATCH) |=> (wide_pin_o == $past(pwdata[WIDE_W-1:0])))
        else $error("wide latch write lost");

    // pin register write lands in the latch
    a_wide_pins_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_dir_write(DGP_OFF_WIDE_PINS) |=> (wide_pin_o == $past(pwdata[WIDE_W-1:0])))
        else $error("wide pin write missed latch");

    a_wide_pins_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg_read(DGP_OFF_WIDE_PINS) |=> (prdata[WIDE_W-1:0] == $past(wide_sync)))
        else $error("wide pin read not pin level");

    a_nar_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_dir_write(DGP_OFF_NARROW_LAT) |=> (narrow_pin_o == $past(pwdata[NARROW_W-1:0])))
        else $error("narrow latch write lost");

    a_nar_latch_rmw: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg_read(DGP_OFF_NARROW_LAT) |=> (prdata[NARROW_W-1:0] == narrow_pin_o)
        && (prdata[31:NARROW_W] == '0))
        else $error("narrow latch readback wrong");

    // narrow pin register write lands in the latch
    a_nar_pins_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_dir_write(DGP_OFF_NARROW_PINS) |=> (narrow_pin_o == $past(pwdata[NARROW_W-1:0])))
        else $error("narrow pin write missed latch");

    // digital narrow pins read their levels
    a_nar_digital_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && !pready && soft_rst_n && paddr == DGP_OFF_NARROW_PINS
        && st_q.analog_cfg == DGP_ANALOG_ALL_DIG) |=> (prdata[NARROW_W-1:0] == $past(nar_sync)))
        else $error("narrow digital read wrong");

    // flags and the bit above the direction bits read zero
    a_nar_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_reg_read(DGP_OFF_NARROW_DIR) |=> (prdata[31:DGP_BIT_IN_OVF] == '0)
        && !prdata[NARROW_W] && (prdata[NARROW_W-1:0] == ~narrow_pin_oe))
        else $error("narrow control readback wrong");

    a_nar_input_float: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q.nar_dir == '1) |-> (narrow_pin_oe == '0))
        else $error("narrow input pin driven");

    // other reset leaves latches and wide direction alone
    a_soft_keep_latch: assert property (@(posedge pclk) disable iff (!presetn)
        !soft_rst_n |=> $stable(wide_pin_o) && $stable(narrow_pin_o) && $stable(st_q.wide_dir))
        else $error("other reset disturbed latches");
endmodule // dgp_top

`default_nettype wire

// ---- tb/dgp_pin_model.sv ----
// External circuitry on one port: resolves the wire and feeds it back
`timescale 1ns/1ps
`default_nettype none
module dgp_pin_model #(
    parameter int unsigned W = 8
) (
    input  wire logic         pclk,    // System clock
    input  wire logic [W-1:0] pin_o,   // Device drive value
    input  wire logic [W-1:0] pin_oe,  // Device drive enable
    input  wire logic [W-1:0] ext_val, // Outside drive value
    input  wire logic [W-1:0] ext_en,  // Outside drive enable
    output var  logic [W-1:0] pin_lvl  // Resolved wire level
);
    logic [W-1:0] last_q = '0;
    // No pull resistor: a floating pin shows the inverse of the level last driven
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            pin_lvl[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : ~last_q[i]);
        end
    end
    // Only driven levels are remembered, so a floating pin holds still
    always_ff @(posedge pclk)
    begin
        for (int i = 0; i < W; i++)
        begin
            if (pin_oe[i] || ext_en[i])
                last_q[i] <= pin_lvl[i];
        end
    end
endmodule // dgp_pin_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the dual general-purpose port block
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dgp_pkg::*;
;
    typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [7:0] rv; logic er;}
        dgp_row_s;
    logic        pclk, presetn, soft_rst_n, psel, penable, pwrite, pready, pslverr, host;
    logic [7:0]  paddr, w_o, w_oe, w_lvl, w_ev, w_ee;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [2:0]  n_o, n_oe, n_lvl, n_ev, n_ee;
    logic        er;
    int          error_cnt, n_compared;
    dgp_row_s    rows [16];

    dgp_top u_dgp_top (.pclk(pclk), .presetn(presetn), .soft_rst_n(soft_rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .wide_pin_i(w_lvl),
        .wide_pin_o(w_o), .wide_pin_oe(w_oe), .narrow_pin_i(n_lvl), .narrow_pin_o(n_o),
        .narrow_pin_oe(n_oe), .host_port_mode_select(host));
    dgp_pin_model #(.W(8)) u_wide_model (.pclk(pclk), .pin_o(w_o), .pin_oe(w_oe),
        .ext_val(w_ev), .ext_en(w_ee), .pin_lvl(w_lvl));
    dgp_pin_model #(.W(3)) u_narrow_model (.pclk(pclk), .pin_o(n_o), .pin_oe(n_oe),
        .ext_val(n_ev), .ext_en(n_ee), .pin_lvl(n_lvl));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Setup, access, hold until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hF);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // A hung answer is ended by the watchdog
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, {24'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        finish_test();
    end
    initial
    begin
        presetn = 1'b0; soft_rst_n = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; pstrb = 4'hF;
        w_ev = 8'h0A; w_ee = 8'hCF; n_ev = 3'h2; n_ee = 3'h7;
        rows = '{'{1'b1, 8'h04, 32'hFFFFFF5A, 8'h00, 1'b0}, '{1'b0, 8'h04, 32'h0, 8'h5A, 1'b0},
                 '{1'b1, 8'h00, 32'h000000C3, 8'h00, 1'b0}, '{1'b0, 8'h04, 32'h0, 8'hC3, 1'b0},
                 '{1'b1, 8'h08, 32'h000000CF, 8'h00, 1'b0}, '{1'b0, 8'h08, 32'h0, 8'hCF, 1'b0},
                 '{1'b1, 8'h10, 32'h00000006, 8'h00, 1'b0}, '{1'b0, 8'h10, 32'h0, 8'h06, 1'b0},
                 '{1'b1, 8'h14, 32'h000000FF, 8'h00, 1'b0}, '{1'b0, 8'h14, 32'h0, 8'h17, 1'b0},
                 '{1'b1, 8'h14, 32'h000000EF, 8'h00, 1'b0}, '{1'b0, 8'h14, 32'h0, 8'h07, 1'b0},
                 '{1'b1, 8'h1C, 32'h12345678, 8'h00, 1'b1}, '{1'b0, 8'h1C, 32'h0, 8'h00, 1'b1},
                 '{1'b1, 8'h0C, 32'h00000005, 8'h00, 1'b0}, '{1'b0, 8'h10, 32'h0, 8'h05, 1'b0}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({w_oe, 5'h0, n_oe, 7'h0, host}, 32'h0); // inputs after reset
        rdchk(DGP_OFF_WIDE_DIR, 8'hFF); // all inputs
        rdchk(DGP_OFF_NARROW_DIR, 8'h07); // reset value
        rdchk(DGP_OFF_ANALOG_CFG, 8'h00); // all analog
        // Latch, direction, reserved bits and an unmapped address
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d); // narrow pins stay inputs while analog
            chk({31'h0, er}, {31'h0, rows[i].er}); // error flag
            if (!rows[i].wr)
                chk(rd, {24'h0, rows[i].rv}); // read value
        end
        @(negedge pclk);
        chk({w_oe, w_o}, 32'h30C3); // wide drivers
        chk({n_oe, n_o, host}, 32'h0A); // narrow drivers while analog
        repeat (4) @(posedge pclk);
        rdchk(DGP_OFF_WIDE_PINS, 8'h0A); // pin levels, not latch
        rdchk(DGP_OFF_NARROW_PINS, 8'h00); // analog pins read zero
        // Pins made digital before use
        apb(1'b1, DGP_OFF_ANALOG_CFG, {29'h0, DGP_ANALOG_ALL_DIG}); // software setup
        // Outside lets go of the pins that the block is about to drive
        n_ee <= 3'h2;
        apb(1'b1, DGP_OFF_NARROW_DIR, 32'h02); // outputs only once digital
        @(negedge pclk);
        chk({n_oe, n_o}, 32'h2D); // narrow pins 0 and 2 driven from latch
        rdchk(DGP_OFF_NARROW_PINS, 8'h07); // digital pin levels
        apb(1'b1, DGP_OFF_WIDE_LATCH, 32'h11, 4'h0);
        rdchk(DGP_OFF_WIDE_LATCH, 8'hC3); // strobe-less write ignored
        apb(1'b1, DGP_OFF_NARROW_DIR, 32'h17);
        @(negedge pclk);
        chk({w_oe, 7'h0, host}, 32'h1); // host mode releases wide drivers
        // Other reset keeps latches and wide direction
        @(posedge pclk);
        soft_rst_n <= 1'b0;
        repeat (2) @(posedge pclk);
        soft_rst_n <= 1'b1;
        rdchk(DGP_OFF_NARROW_DIR, 8'h07); // back to reset value
        rdchk(DGP_OFF_WIDE_LATCH, 8'hC3); // latch kept
        rdchk(DGP_OFF_WIDE_DIR, 8'hCF); // direction kept
        rdchk(DGP_OFF_NARROW_LAT, 8'h05); // narrow latch kept
        // Power-on reset in mid-run
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(DGP_OFF_WIDE_DIR, 8'hFF); // back to inputs
        rdchk(DGP_OFF_NARROW_PINS, 8'h00); // analog again
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
